// File: ikd_regs.vh
// Constants, opcode patterns and timing counts of the instruction decoder.
// Notes on behaviour
// [RL1] Table write to internal memory programs over many cycles; any interrupt ends it.
// [RL2] Table write to external program memory takes exactly two cycles.
// [RL3] Latch write opcode 1010 01tx: one cycle, t picks the latch half.
// [RL4] With s set only the file is written; with s clear both file and working register.
// [RL5] Long call loads pc from pc_latch_high and the literal in two cycles.
// [RL6] Conditional skips take two cycles when the test holds, else one.
// [RL7] Table read takes two cycles, three when the destination is the pc low byte.
// [RL8] On a skip the already fetched word is discarded and a no-operation runs.
// [RL9] Opcode 1001 1bbb skips when the selected file bit is zero; no flags change.
// [RL10] Opcode 1001 0bbb skips when the selected file bit is one; no flags change.
// [RL11] Word 0000 0000 0000 0101 returns from interrupt in two cycles, enabling interrupts.
// [RL12] Opcode 1011 1000 loads the low bank select nibble in one cycle.
// [RL13] Opcode 1011 101x loads the high bank select nibble in one cycle.
// [RL14] Opcode 1011 1100 multiplies literal by working register in one cycle, flags kept.
// [RL15] Opcode 1011 0101 ANDs the literal into the working register; only zero flag.
// [RL16] Opcode 1011 0011 ORs the literal into the working register; only zero flag.
// [RL17] Opcode 1011 0100 XORs the literal into the working register; only zero flag.
// [RL18] Opcode 1011 0010 computes literal minus working register, all four arithmetic flags.
// [RL19] Opcode 1011 0110 returns from subroutine with the literal in the working register.
// [RL20] Opcode 0000 110d XORs working and file register in one cycle; only zero flag.
// [RL21] Opcode 1011 0000 copies the literal into the working register, flags kept.
// [RL22] A d of zero sends the result to the working register, one to the file.
// [RL23] Any undefined opcode is a one-cycle no-operation that changes nothing; the decoder still loads its low byte into file_wr_addr_q.
`ifndef IKD_REGS_VH
`define IKD_REGS_VH

// High byte patterns, matched with casez, and the low byte of the interrupt return word.
`define IKD_PAT_LATCH_RD 8'b1010_00??
`define IKD_PAT_LATCH_WR 8'b1010_01??
`define IKD_PAT_TBL_RD 8'b1010_10??
`define IKD_PAT_TBL_WR 8'b1010_11??
`define IKD_PAT_SKIP_CLR 8'b1001_1???
`define IKD_PAT_SKIP_SET 8'b1001_0???
`define IKD_PAT_LONG_CALL_OP 8'b1011_0111
`define IKD_PAT_BANK_LO 8'b1011_1000
`define IKD_PAT_BANK_HI 8'b1011_101?
`define IKD_PAT_MUL 8'b1011_1100
`define IKD_PAT_AND 8'b1011_0101
`define IKD_PAT_OR 8'b1011_0011
`define IKD_PAT_XOR 8'b1011_0100
`define IKD_PAT_SUB 8'b1011_0010
`define IKD_PAT_RETLIT 8'b1011_0110
`define IKD_PAT_LOAD 8'b1011_0000
`define IKD_PAT_FXOR 8'b0000_110?
`define IKD_PAT_SETF 8'b0010_101?
`define IKD_PAT_CTRL 8'b0000_0000
`define IKD_LOW_INT_RET 8'h05

// Field positions inside the instruction word.
`define IKD_BIT_T 9
`define IKD_BIT_I 8
`define IKD_BIT_D 8
`define IKD_BIT_S 8

// File address of the pc low byte.
`define IKD_ADDR_PC_LOW 8'h02

// Extra cycles beyond the first for multi-cycle forms.
`define IKD_XTRA_TWO 2'h1
`define IKD_XTRA_THREE 2'h2

// Alu operation selects.
`define IKD_ALU_AND 2'h0
`define IKD_ALU_OR 2'h1
`define IKD_ALU_XOR 2'h2
`define IKD_ALU_SUB 2'h3

// Reset values.
`define IKD_RST_BYTE 8'h00
`define IKD_RST_GID 1'b1

`endif

// File: ikd_alu.v
// Logic and subtract unit of the instruction decoder.
`timescale 1ns/1ps
`include "ikd_regs.vh"
module ikd_alu (
    input wire [1:0] op,
    input wire [7:0] a,
    input wire [7:0] w,
    output reg [7:0] res,
    output reg c,
    output reg dc,
    output reg ov,
    output wire z
);
    always @* begin
        c = 1'b0;
        dc = 1'b0;
        ov = 1'b0;
        case (op)
            `IKD_ALU_AND: res = a & w;
            `IKD_ALU_OR: res = a | w;
            `IKD_ALU_XOR: res = a ^ w;
            default: begin
                // Carry means no borrow, as in a two's complement subtract.
                res = a - w;
                c = (a >= w);
                dc = (a[3:0] >= w[3:0]);
                ov = (a[7] ^ w[7]) & (a[7] ^ res[7]);
            end
        endcase
    end
    assign z = (res == 8'h00);
endmodule // ikd_alu

// File: ikd_mul8.v
// Unsigned eight by eight single-cycle multiplier.
`timescale 1ns/1ps
module ikd_mul8 (
    input wire [7:0] a,
    input wire [7:0] b,
    output wire [15:0] p
);
    assign p = {8'h00, a} * {8'h00, b};
endmodule // ikd_mul8

// File: ikd_insn_decoder.v
// Decoder and sequencer for table, bit-test, literal and control instructions.
`timescale 1ns/1ps
`include "ikd_regs.vh"
module ikd_insn_decoder (
    input wire clk_sys,
    input wire rst,
    input wire insn_valid,
    input wire [15:0] insn_word,
    input wire [7:0] file_rd_data,
    input wire [7:0] pc_latch_high,
    input wire [15:0] tbl_latch_rd,
    input wire tbl_internal,
    input wire int_event,
    output reg insn_ready_q,
    output reg fetch_discard_q,
    output reg [7:0] working_register_q,
    output reg [7:0] bank_select_register_q,
    output reg overflow_flag_q,
    output reg carry_flag_q,
    output reg digit_carry_flag_q,
    output reg zero_flag_q,
    output reg global_interrupt_disable_q,
    output reg file_wr_en_q,
    output reg [7:0] file_wr_addr_q,
    output reg [7:0] file_wr_data_q,
    output reg pc_load_q,
    output reg [15:0] pc_load_value_q,
    output reg stack_push_q,
    output reg stack_pop_q,
    output reg prod_wr_q,
    output reg [15:0] prod_q,
    output reg tbl_latch_wr_q,
    output reg tbl_latch_hi_q,
    output reg [7:0] tbl_latch_data_q,
    output reg tbl_rd_start_q,
    output reg tbl_wr_start_q,
    output reg tbl_ptr_inc_q,
    output reg tbl_prog_active_q
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_WAIT = 3'b010;
    localparam [2:0] S_PROG = 3'b100;

    ////////////////////////////////////////////////////////////////////////////////
    // Operand fields and shared arithmetic.

    wire [7:0] op_hi = insn_word[15:8];
    wire [7:0] lit = insn_word[7:0];
    wire [2:0] bit_sel = insn_word[10:8];
    wire sel_bit = file_rd_data[bit_sel];
    wire take = insn_valid & insn_ready_q;

    reg [1:0] alu_op;
    reg [7:0] alu_a;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_dc;
    wire alu_ov;
    wire alu_z;
    wire [15:0] mul_p;

    ikd_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .w(working_register_q),
        .res(alu_res),
        .c(alu_c),
        .dc(alu_dc),
        .ov(alu_ov),
        .z(alu_z)
    );

    ikd_mul8 u_mul (
        .a(lit),
        .b(working_register_q),
        .p(mul_p)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state decode.

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg [1:0] xtra;
    reg discard_d;
    reg ready_d;
    reg [7:0] w_d;
    reg [7:0] bank_d;
    reg ov_d;
    reg c_d;
    reg dc_d;
    reg z_d;
    reg gid_d;
    reg fwe_d;
    reg [7:0] fdata_d;
    reg pcl_d;
    reg [15:0] pcv_d;
    reg push_d;
    reg pop_d;
    reg pwe_d;
    reg [15:0] prod_d;
    reg tlwe_d;
    reg tlhi_d;
    reg [7:0] tldata_d;
    reg trd_d;
    reg twr_d;
    reg tinc_d;
    reg prog_d;

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        xtra = 2'h0;
        discard_d = 1'b0;
        ready_d = insn_ready_q;
        w_d = working_register_q;
        bank_d = bank_select_register_q;
        ov_d = overflow_flag_q;
        c_d = carry_flag_q;
        dc_d = digit_carry_flag_q;
        z_d = zero_flag_q;
        gid_d = global_interrupt_disable_q;
        fwe_d = 1'b0;
        fdata_d = file_wr_data_q;
        pcl_d = 1'b0;
        pcv_d = pc_load_value_q;
        push_d = 1'b0;
        pop_d = 1'b0;
        pwe_d = 1'b0;
        prod_d = prod_q;
        tlwe_d = 1'b0;
        tlhi_d = tbl_latch_hi_q;
        tldata_d = tbl_latch_data_q;
        trd_d = 1'b0;
        twr_d = 1'b0;
        tinc_d = 1'b0;
        prog_d = tbl_prog_active_q;
        alu_op = `IKD_ALU_AND;
        alu_a = lit;
        case (state_q)
            S_IDLE: begin
                if (take) begin
                    casez (op_hi)
                        `IKD_PAT_LATCH_WR: begin
                            tlwe_d = 1'b1; // RL3
                            tlhi_d = insn_word[`IKD_BIT_T]; // RL3
                            tldata_d = file_rd_data;
                        end
                        `IKD_PAT_LATCH_RD: begin
                            fwe_d = 1'b1;
                            fdata_d = insn_word[`IKD_BIT_T] ? tbl_latch_rd[15:8] :
                                tbl_latch_rd[7:0];
                        end
                        `IKD_PAT_TBL_RD: begin
                            trd_d = 1'b1;
                            tinc_d = insn_word[`IKD_BIT_I];
                            // Reloading the pc low byte costs one more flush cycle.
                            if (lit == `IKD_ADDR_PC_LOW) begin
                                xtra = `IKD_XTRA_THREE; // RL7
                            end else begin
                                xtra = `IKD_XTRA_TWO; // RL7
                            end
                        end
                        `IKD_PAT_TBL_WR: begin
                            tlwe_d = 1'b1;
                            tlhi_d = insn_word[`IKD_BIT_T];
                            tldata_d = file_rd_data;
                            twr_d = 1'b1;
                            tinc_d = insn_word[`IKD_BIT_I];
                            if (tbl_internal) begin
                                prog_d = 1'b1; // RL1
                            end else begin
                                xtra = `IKD_XTRA_TWO; // RL2
                            end
                        end
                        `IKD_PAT_SKIP_CLR: begin
                            if (!sel_bit) begin
                                xtra = `IKD_XTRA_TWO; // RL9 RL6
                                discard_d = 1'b1; // RL8
                            end
                        end
                        `IKD_PAT_SKIP_SET: begin
                            if (sel_bit) begin
                                xtra = `IKD_XTRA_TWO; // RL10 RL6
                                discard_d = 1'b1; // RL8
                            end
                        end
                        `IKD_PAT_LONG_CALL_OP: begin
                            push_d = 1'b1;
                            pcl_d = 1'b1;
                            pcv_d = {pc_latch_high, lit}; // RL5
                            xtra = `IKD_XTRA_TWO; // RL5
                            discard_d = 1'b1;
                        end
                        `IKD_PAT_BANK_LO: begin
                            bank_d = {bank_select_register_q[7:4], lit[3:0]}; // RL12
                        end
                        `IKD_PAT_BANK_HI: begin
                            bank_d = {lit[7:4], bank_select_register_q[3:0]}; // RL13
                        end
                        `IKD_PAT_MUL: begin
                            pwe_d = 1'b1;
                            prod_d = mul_p; // RL14
                        end
                        `IKD_PAT_AND: begin
                            alu_op = `IKD_ALU_AND;
                            w_d = alu_res; // RL15
                            z_d = alu_z; // RL15
                        end
                        `IKD_PAT_OR: begin
                            alu_op = `IKD_ALU_OR;
                            w_d = alu_res; // RL16
                            z_d = alu_z; // RL16
                        end
                        `IKD_PAT_XOR: begin
                            alu_op = `IKD_ALU_XOR;
                            w_d = alu_res; // RL17
                            z_d = alu_z; // RL17
                        end
                        `IKD_PAT_SUB: begin
                            alu_op = `IKD_ALU_SUB;
                            w_d = alu_res; // RL18
                            ov_d = alu_ov; // RL18
                            c_d = alu_c; // RL18
                            dc_d = alu_dc; // RL18
                            z_d = alu_z; // RL18
                        end
                        `IKD_PAT_RETLIT: begin
                            w_d = lit; // RL19
                            pop_d = 1'b1;
                            xtra = `IKD_XTRA_TWO; // RL19
                            discard_d = 1'b1;
                        end
                        `IKD_PAT_LOAD: begin
                            w_d = lit; // RL21
                        end
                        `IKD_PAT_FXOR: begin
                            alu_op = `IKD_ALU_XOR;
                            alu_a = file_rd_data;
                            z_d = alu_z; // RL20
                            if (insn_word[`IKD_BIT_D]) begin
                                fwe_d = 1'b1; // RL22
                                fdata_d = alu_res;
                            end else begin
                                w_d = alu_res; // RL22
                            end
                        end
                        `IKD_PAT_SETF: begin
                            fwe_d = 1'b1; // RL4
                            fdata_d = 8'hFF;
                            if (!insn_word[`IKD_BIT_S]) begin
                                w_d = 8'hFF; // RL4
                            end
                        end
                        `IKD_PAT_CTRL: begin
                            if (lit == `IKD_LOW_INT_RET) begin
                                gid_d = 1'b0; // RL11
                                pop_d = 1'b1;
                                xtra = `IKD_XTRA_TWO; // RL11
                                discard_d = 1'b1;
                            end
                        end
                        default: begin
                            // Unknown words fall through with every default held.
                            xtra = 2'h0; // RL23
                        end
                    endcase
                    if (prog_d) begin
                        state_d = S_PROG;
                        ready_d = 1'b0;
                    end else if (xtra != 2'h0) begin
                        state_d = S_WAIT;
                        cnt_d = xtra - 2'h1;
                        ready_d = 1'b0;
                    end
                end
            end
            S_WAIT: begin
                if (cnt_q == 2'h0) begin
                    state_d = S_IDLE;
                    ready_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 2'h1;
                end
            end
            S_PROG: begin
                // Programming has no end of its own; only an interrupt closes it.
                if (int_event) begin
                    prog_d = 1'b0; // RL1
                    state_d = S_IDLE;
                    ready_d = 1'b1;
                end
            end
            default: begin
                state_d = S_IDLE;
                ready_d = 1'b1;
                prog_d = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State and output registers.

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q <= 2'h0;
            insn_ready_q <= 1'b1;
            fetch_discard_q <= 1'b0;
            working_register_q <= `IKD_RST_BYTE;
            bank_select_register_q <= `IKD_RST_BYTE;
            overflow_flag_q <= 1'b0;
            carry_flag_q <= 1'b0;
            digit_carry_flag_q <= 1'b0;
            zero_flag_q <= 1'b0;
            global_interrupt_disable_q <= `IKD_RST_GID;
            file_wr_en_q <= 1'b0;
            file_wr_addr_q <= `IKD_RST_BYTE;
            file_wr_data_q <= `IKD_RST_BYTE;
            pc_load_q <= 1'b0;
            pc_load_value_q <= 16'h0000;
            stack_push_q <= 1'b0;
            stack_pop_q <= 1'b0;
            prod_wr_q <= 1'b0;
            prod_q <= 16'h0000;
            tbl_latch_wr_q <= 1'b0;
            tbl_latch_hi_q <= 1'b0;
            tbl_latch_data_q <= `IKD_RST_BYTE;
            tbl_rd_start_q <= 1'b0;
            tbl_wr_start_q <= 1'b0;
            tbl_ptr_inc_q <= 1'b0;
            tbl_prog_active_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            insn_ready_q <= ready_d;
            fetch_discard_q <= discard_d;
            working_register_q <= w_d;
            bank_select_register_q <= bank_d;
            overflow_flag_q <= ov_d;
            carry_flag_q <= c_d;
            digit_carry_flag_q <= dc_d;
            zero_flag_q <= z_d;
            global_interrupt_disable_q <= gid_d;
            file_wr_en_q <= fwe_d;
            if (take) begin
                file_wr_addr_q <= lit;
            end
            file_wr_data_q <= fdata_d;
            pc_load_q <= pcl_d;
            pc_load_value_q <= pcv_d;
            stack_push_q <= push_d;
            stack_pop_q <= pop_d;
            prod_wr_q <= pwe_d;
            prod_q <= prod_d;
            tbl_latch_wr_q <= tlwe_d;
            tbl_latch_hi_q <= tlhi_d;
            tbl_latch_data_q <= tldata_d;
            tbl_rd_start_q <= trd_d;
            tbl_wr_start_q <= twr_d;
            tbl_ptr_inc_q <= tinc_d;
            tbl_prog_active_q <= prog_d;
        end
    end
endmodule // ikd_insn_decoder

// File: ikd_insn_decoder_properties.sv
// Concurrent checks on the port behaviour of the instruction decoder.
`timescale 1ns/1ps
module ikd_insn_decoder_properties (
    input wire clk_sys,
    input wire rst,
    input wire insn_valid,
    input wire [15:0] insn_word,
    input wire [7:0] file_rd_data,
    input wire [7:0] pc_latch_high,
    input wire tbl_internal,
    input wire int_event,
    input wire insn_ready_q,
    input wire fetch_discard_q,
    input wire [7:0] working_register_q,
    input wire [7:0] bank_select_register_q,
    input wire overflow_flag_q,
    input wire carry_flag_q,
    input wire digit_carry_flag_q,
    input wire zero_flag_q,
    input wire global_interrupt_disable_q,
    input wire pc_load_q,
    input wire [15:0] pc_load_value_q,
    input wire prod_wr_q,
    input wire [15:0] prod_q,
    input wire tbl_wr_start_q,
    input wire tbl_prog_active_q
);
    ////////////////////////////////////////
    wire take = insn_valid && insn_ready_q;
    wire [7:0] hi = insn_word[15:8];
    wire [3:0] fl = {overflow_flag_q, carry_flag_q, digit_carry_flag_q, zero_flag_q};
    default clocking dc_cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    chk_long_call_op_target: assert property (take && hi == 8'hB7 |=> pc_load_q
        && pc_load_value_q == {$past(pc_latch_high), $past(insn_word[7:0])}
        && !insn_ready_q ##1 insn_ready_q) else $error("long call target or length wrong");
    chk_load_keeps: assert property (take && hi == 8'hB0 |=> $stable(fl)
        && working_register_q == $past(insn_word[7:0])) else $error("literal load wrong");
    chk_and_zero: assert property (take && hi == 8'hB5 |=> $stable(fl[3:1])
        && working_register_q == ($past(working_register_q) & $past(insn_word[7:0]))
        && zero_flag_q == (working_register_q == 8'h00)) else $error("and literal wrong");
    chk_mul_product: assert property (take && hi == 8'hBC |=> prod_wr_q && $stable(fl)
        && prod_q == {8'h00, $past(working_register_q)} * {8'h00, $past(insn_word[7:0])})
        else $error("product wrong");
    chk_skip_decide: assert property (take && insn_word[15:12] == 4'h9 |=>
        fetch_discard_q == ($past(file_rd_data[insn_word[10:8]]) != $past(insn_word[11])))
        else $error("skip decision wrong");
    chk_skip_slot: assert property (take && insn_word[15:12] == 4'h9
        && file_rd_data[insn_word[10:8]] != insn_word[11] |=> !insn_ready_q ##1 insn_ready_q)
        else $error("skip length wrong");
    chk_int_return: assert property (take && insn_word == 16'h0005 |=>
        !global_interrupt_disable_q && !insn_ready_q ##1 insn_ready_q)
        else $error("interrupt return wrong");
    chk_tblrd_pcl: assert property (take && insn_word[15:10] == 6'b101010
        && insn_word[7:0] == 8'h02 |=> !insn_ready_q [*2] ##1 insn_ready_q)
        else $error("table read to pc low length wrong");
    chk_tblwt_ext: assert property (take && insn_word[15:10] == 6'b101011
        && !tbl_internal |=> tbl_wr_start_q && !insn_ready_q ##1 insn_ready_q)
        else $error("external table write length wrong");
    chk_prog_abort: assert property (tbl_prog_active_q && int_event |=>
        !tbl_prog_active_q && insn_ready_q) else $error("programming not ended");
    chk_bank_low: assert property (take && hi == 8'hB8 |=>
        bank_select_register_q == {$past(bank_select_register_q[7:4]), $past(insn_word[3:0])})
        else $error("bank low nibble wrong");
    chk_bank_high: assert property (take && insn_word[15:9] == 7'b1011101 |=>
        bank_select_register_q == {$past(insn_word[7:4]), $past(bank_select_register_q[3:0])})
        else $error("bank high nibble wrong");
    cov_long_call: cover property (take && hi == 8'hB7);
    cov_skip: cover property (fetch_discard_q && !insn_ready_q);
    cov_prog_end: cover property (tbl_prog_active_q && int_event);
endmodule // ikd_insn_decoder_properties

// File: ikd_pmem_model.sv
// Behavioural data file and pc latch source facing the decoder.
`timescale 1ns/1ps
module ikd_pmem_model #(
    parameter [7:0] LATCH_HI = 8'h3C
) (
    input wire clk_sys,
    input wire [15:0] insn_word,
    input wire file_wr_en_q,
    input wire [7:0] file_wr_addr_q,
    input wire [7:0] file_wr_data_q,
    output wire [7:0] file_rd_data,
    output wire [7:0] pc_latch_high,
    output wire [15:0] tbl_latch_rd
);
    ////////////////////////////////////////
    logic [7:0] mem [0:255];
    // The read is combinational because the decoder tests bits in the cycle a word is offered.
    assign file_rd_data = mem[insn_word[7:0]];
    assign pc_latch_high = LATCH_HI;
    assign tbl_latch_rd = 16'h5AA5;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        mem[8'h20] = 8'h01;
    end
    always @(posedge clk_sys) begin
        if (file_wr_en_q) begin
            mem[file_wr_addr_q] <= file_wr_data_q;
        end
    end
endmodule // ikd_pmem_model

// File: ikd_insn_decoder_tb_top.sv
// Directed bench for the decoder: instruction sequences with expected results.
`timescale 1ns/1ps
module ikd_insn_decoder_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic insn_valid = 1'b0;
    logic tbl_internal = 1'b0;
    logic int_event = 1'b0;
    logic [15:0] insn_word = 16'h0000;
    wire [7:0] file_rd_data, pc_latch_high, working_register_q, bank_select_register_q;
    wire [7:0] file_wr_addr_q, file_wr_data_q, tbl_latch_data_q;
    wire [15:0] tbl_latch_rd, pc_load_value_q, prod_q;
    wire insn_ready_q, fetch_discard_q, overflow_flag_q, carry_flag_q, digit_carry_flag_q;
    wire zero_flag_q, global_interrupt_disable_q, file_wr_en_q, pc_load_q, stack_push_q;
    wire stack_pop_q, prod_wr_q, tbl_latch_wr_q, tbl_latch_hi_q, tbl_rd_start_q;
    wire tbl_wr_start_q, tbl_ptr_inc_q, tbl_prog_active_q;
    wire [3:0] fl = {overflow_flag_q, carry_flag_q, digit_carry_flag_q, zero_flag_q};
    int failures = 0;
    int checked = 0;
    // Word, working register after it, then flags as overflow, carry, digit carry, zero.
    logic [27:0] tl [0:12] = '{28'hB0A3_A30, 28'hB55F_030, 28'hB001_010, 28'hB280_7FC,
        28'hB500_00D, 28'hB300_00D, 28'hB380_80C, 28'hB480_00D, 28'hB005_05D,
        28'hB205_007, 28'hB005_057, 28'hB203_FE0, 28'hB010_100};
    logic [16:0] sk [0:3] = '{17'h0_9820, 17'h1_9920, 17'h1_9020, 17'h0_9120};
    ikd_insn_decoder dut_u (.*);
    ikd_pmem_model mdl_u (.*);
    ////////////////////////////////////////
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Counts the cycles with ready low; a stuck decoder ends the run instead of hanging it.
    task automatic cyc(input int e);
        int n;
        n = 0;
        while (insn_ready_q !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (insn_ready_q !== 1'b1) begin
            failures++;
            end_sim();
        end else begin
            chk("wait cycles", 16'(e), 16'(n));
        end
    endtask
    task automatic op(input logic [15:0] w);
        cyc(0);
        @(posedge clk_sys);
        insn_valid <= 1'b1;
        insn_word <= w;
        @(posedge clk_sys);
        insn_valid <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("reset state", 16'h0100, 16'({global_interrupt_disable_q, bank_select_register_q}));
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            op(tl[i][27:12]);
            chk("working", 16'(tl[i][11:4]), 16'(working_register_q));
            chk("flags", 16'(tl[i][3:0]), 16'(fl));
        end
        op(16'hBC21);
        chk("product", 16'h0210, prod_q);
        chk("mul side", 16'h1010, 16'({prod_wr_q, fl, working_register_q}));
        $display("test literal done");
        op(16'hB8F5);
        chk("bank", 16'h0005, 16'(bank_select_register_q));
        op(16'hBBA7);
        chk("bank", 16'h00A5, 16'(bank_select_register_q));
        op(16'hBA3F);
        chk("bank", 16'h0035, 16'(bank_select_register_q));
        for (int i = 0; i < 4; i++) begin
            op(sk[i][15:0]);
            chk("discard", 16'(sk[i][16]), 16'(fetch_discard_q));
            cyc(sk[i][16]);
        end
        $display("test bank and skip done");
        op(16'hB7C4);
        chk("call target", 16'h3CC4, pc_load_value_q);
        chk("call pulses", 16'h0007, 16'({pc_load_q, stack_push_q, fetch_discard_q}));
        cyc(1);
        op(16'hB699);
        chk("return", 16'h0199, 16'({stack_pop_q, working_register_q}));
        cyc(1);
        op(16'h0005);
        chk("gid", 16'h0000, 16'(global_interrupt_disable_q));
        cyc(1);
        op(16'h7E00);
        chk("undefined", 16'h0099, 16'({file_wr_en_q, working_register_q}));
        cyc(0);
        $display("test control done");
        op(16'hA620);
        chk("latch", 16'h0301, 16'({tbl_latch_wr_q, tbl_latch_hi_q, tbl_latch_data_q}));
        cyc(0);
        op(16'hA230);
        chk("latch read", 16'h015A, 16'({file_wr_en_q, file_wr_data_q}));
        op(16'hA902);
        chk("read start", 16'h0003, 16'({tbl_rd_start_q, tbl_ptr_inc_q}));
        cyc(2);
        op(16'hA820);
        cyc(1);
        op(16'hAC20);
        chk("write start", 16'h0001, 16'(tbl_wr_start_q));
        cyc(1);
        @(posedge clk_sys);
        tbl_internal <= 1'b1;
        op(16'hAC20);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("programming", 16'h0002, 16'({tbl_prog_active_q, insn_ready_q}));
        @(posedge clk_sys);
        int_event <= 1'b1;
        @(posedge clk_sys);
        int_event <= 1'b0;
        #1;
        chk("programming end", 16'h0001, 16'({tbl_prog_active_q, insn_ready_q}));
        $display("test table done");
        op(16'h0C20);
        chk("xor to working", 16'h0098, 16'({zero_flag_q, working_register_q}));
        op(16'h0D20);
        chk("xor to file", 16'h2099, {file_wr_addr_q, file_wr_data_q});
        chk("xor keeps", 16'h0198, 16'({file_wr_en_q, working_register_q}));
        op(16'h2B30);
        chk("set file only", 16'h0198, 16'({file_wr_en_q, working_register_q}));
        op(16'h2A30);
        chk("set both", 16'h30FF, {file_wr_addr_q, working_register_q});
        $display("test file done");
        end_sim();
    end
endmodule // ikd_insn_decoder_tb_top
bind ikd_insn_decoder ikd_insn_decoder_properties chk_u (.*);
